// ### common/dac_span_map.svh
// command codes, field positions, reset values and frame lengths
`ifndef DAC_SPAN_MAP_SVH
`define DAC_SPAN_MAP_SVH
// upper nibble of the command byte
`define CMD_WR_CODE 4'h0
`define CMD_WR_SET 4'h1
`define CMD_WR_OFS 4'h2
`define CMD_WR_GAIN 4'h3
`define CMD_WR_CODE_UPD 4'h4
`define CMD_WR_CODE_UPDALL 4'h5
`define CMD_UPD 4'h6
`define CMD_ALL 4'h7
`define CMD_RD_ADJ 4'h8
`define CMD_RD_SET 4'h9
`define CMD_RD_OFS 4'ha
`define CMD_RD_GAIN 4'hb
`define CMD_SYS 4'hf
// lower nibble under CMD_ALL and CMD_SYS
`define ALL_WR_CODE 4'h8
`define ALL_WR_CODE_UPD 4'h9
`define ALL_WR_SET 4'ha
`define ALL_WR_SET_UPD 4'hb
`define ALL_UPD 4'hc
`define SYS_RD_CFG 4'h0
// field positions inside the 16 data bits
`define SPAN_LSB 2
`define SPAN_OVR_BIT 3
`define SPAN_MAX_LOW 3'h4
`define OFS_LSB 2
// reset values
`define SPAN_RESET 4'h0
`define CODE_RESET 16'h0000
`define GAIN_RESET 16'h0000
`define OFS_RESET 14'h0000
// frame lengths in serial clocks
`define FRAME_SHORT_BITS 6'd24
`define FRAME_LONG_BITS 6'd32
`endif

// ### common/dac_span_pkg.sv
// types shared by the channel settings logic
package dac_span_pkg;
  typedef logic [3:0] span_type;
  typedef logic [15:0] code_type;
  typedef logic [13:0] offset_type;
  typedef logic [31:0] resp_type;
  typedef struct packed {
    logic evtS1;
    logic evtS2;
    logic evtPrev;
    logic [2:0] cfgS1;
    logic [2:0] cfgS2;
    logic resetFlag;
    logic [7:0][3:0] spanIn;
    logic [7:0][3:0] spanAct;
    logic [7:0][15:0] codeIn;
    logic [7:0][15:0] codeAct;
    logic [7:0][15:0] gain;
    logic [7:0][15:0] settings;
    logic [7:0][13:0] offset;
    logic [7:0] powered;
    resp_type resp;
  } core_state_type;
  typedef struct packed {
    logic [5:0] count;
    logic [31:0] shiftIn;
    resp_type respSh;
  } link_state_type;
endpackage

// ### hdl/dac_span_offset_readback.sv
// per-channel span, offset and readback logic behind the serial link
`timescale 1ns/10ps
`include "dac_span_map.svh"

module dac_span_offset_readback #(
  parameter int CODE_BITS = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic serialClock,
  input wire logic chipSelect_n,
  input wire logic serialDataIn,
  output logic serialDataOut,
  input wire logic thermalShutdownDisable,
  input wire logic externalReferenceSelect,
  input wire logic frameCheckEnable,
  output dac_span_pkg::code_type [7:0] activeCode,
  output dac_span_pkg::span_type [7:0] activeSpan,
  output logic [7:0] channelPowered
);
  import dac_span_pkg::*;

  localparam code_type CODE_MASK = code_type'(16'hffff << (16 - CODE_BITS));

  if (CODE_BITS != 16 && CODE_BITS != 12) begin : gBadBits
    $error("CODE_BITS must be 16 or 12");
  end

  // ---------------- link side, on the serial clock ----------------
  link_state_type l_q;
  link_state_type l_d;
  logic [23:0] frameQ;
  logic evtQ;
  logic sdoQ;
  core_state_type q;
  core_state_type d;

  always_comb begin
    l_d = l_q;
    if (l_q.count != 6'h3f) begin
      l_d.count = l_q.count + 6'h01;
    end
    l_d.shiftIn = {l_q.shiftIn[30:0], serialDataIn};
    // response word is quiet in the core between frames, so a plain
    // capture at the first edge is safe given the idle gap
    if (l_q.count == 6'h00) begin
      l_d.respSh = q.resp;
    end else begin
      l_d.respSh = {l_q.respSh[30:0], 1'b0};
    end
  end

  // the select pin clears the framing state; the link clock stops outside
  always_ff @(posedge serialClock or posedge chipSelect_n) begin
    if (chipSelect_n) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // commands act after 24 bits; a check byte that follows is ignored
  always_ff @(posedge serialClock or negedge rst_n) begin
    if (!rst_n) begin
      frameQ <= '0;
      evtQ <= 1'b0;
    end else if (!chipSelect_n && l_q.count == `FRAME_SHORT_BITS - 6'd1) begin
      frameQ <= l_d.shiftIn[23:0];
      evtQ <= ~evtQ;
    end
  end

  // data changes on the falling edge so the host samples it on the rise
  always_ff @(negedge serialClock or posedge chipSelect_n) begin
    if (chipSelect_n) begin
      sdoQ <= 1'b0;
    end else begin
      sdoQ <= l_q.respSh[30];
    end
  end
  assign serialDataOut = sdoQ;

  // ---------------- core side ----------------
  // gain before offset, twos complement offset in LSBs of the 16-bit code word
  function automatic code_type adjust(input code_type code,
                                      input code_type gain,
                                      input offset_type ofs);
    logic signed [16:0] c;
    logic signed [32:0] p;
    logic signed [19:0] s;
    c = $signed({1'b0, code});
    p = c * $signed(gain);
    s = 20'(c) + 20'(p >>> 16) + 20'($signed(ofs));
    if (s < 0) begin
      return '0;
    end else if (s > 20'sd65535) begin
      return CODE_MASK;
    end else begin
      return s[15:0] & CODE_MASK;
    end
  endfunction

  logic fire;
  logic [7:0] cmd;
  logic [15:0] data;
  logic [2:0] ch;
  logic [7:0] sel;
  logic [7:0] wrCode;
  logic [7:0] wrSet;
  logic [7:0] upd;
  span_type spanField;
  logic spanOk;
  code_type selCode;

  always_comb begin
    d = q;
    d.evtS1 = evtQ;
    d.evtS2 = q.evtS1;
    d.evtPrev = q.evtS2;
    d.cfgS1 = {thermalShutdownDisable, externalReferenceSelect,
               frameCheckEnable};
    d.cfgS2 = q.cfgS1;
    fire = q.evtS2 != q.evtPrev;
    cmd = frameQ[23:16];
    data = frameQ[15:0];
    ch = cmd[3:1];
    sel = 8'h01 << ch;
    selCode = q.codeIn[ch];
    spanField = data[`SPAN_LSB +: 4];
    spanOk = spanField[2:0] <= `SPAN_MAX_LOW;
    wrCode = '0;
    wrSet = '0;
    upd = '0;
    if (fire) begin
      d.resp = '0;
      case (cmd[7:4])
        `CMD_WR_CODE: wrCode = sel;
        `CMD_WR_SET: wrSet = sel;
        `CMD_WR_OFS: d.offset[ch] = data[15:`OFS_LSB];
        `CMD_WR_GAIN: d.gain[ch] = data & CODE_MASK;
        `CMD_WR_CODE_UPD: begin
          wrCode = sel;
          upd = sel;
        end
        `CMD_WR_CODE_UPDALL: begin
          wrCode = sel;
          upd = '1;
        end
        `CMD_UPD: upd = sel;
        `CMD_ALL: begin
          case (cmd[3:0])
            `ALL_WR_CODE: wrCode = '1;
            `ALL_WR_CODE_UPD: begin
              wrCode = '1;
              upd = '1;
            end
            `ALL_WR_SET: wrSet = '1;
            `ALL_WR_SET_UPD: begin
              wrSet = '1;
              upd = '1;
            end
            `ALL_UPD: upd = '1;
            default: ;
          endcase
        end
        `CMD_RD_ADJ: d.resp = {8'h00, q.codeIn[ch], 8'h00};
        `CMD_RD_SET: d.resp = {8'h00, q.settings[ch], 8'h00};
        `CMD_RD_OFS: d.resp = {8'h00, q.offset[ch], 2'b00, 8'h00};
        `CMD_RD_GAIN: d.resp = {8'h00, q.gain[ch], 8'h00};
        `CMD_SYS: begin
          if (cmd[3:0] == `SYS_RD_CFG) begin
            d.resp = {8'h00, q.resetFlag, 7'h00, 5'h00, q.cfgS2,
                      8'h00};
            d.resetFlag = 1'b0;
          end
        end
        default: ;
      endcase
    end
    for (int i = 0; i < 8; i++) begin
      if (wrCode[i]) begin
        // offset and gain only take effect here, at a code write
        d.codeIn[i] = adjust(data & CODE_MASK, d.gain[i],
                             d.offset[i]);
      end
      if (wrSet[i]) begin
        d.settings[i] = data;
        if (spanOk) begin
          d.spanIn[i] = spanField;
        end
      end
      if (upd[i]) begin
        d.codeAct[i] = d.codeIn[i];
        d.spanAct[i] = d.spanIn[i];
        d.powered[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '0;
      q.resetFlag <= 1'b1;
      q.spanIn <= {8{`SPAN_RESET}};
      q.spanAct <= {8{`SPAN_RESET}};
      q.codeIn <= {8{`CODE_RESET}};
      q.codeAct <= {8{`CODE_RESET}};
      q.gain <= {8{`GAIN_RESET}};
      q.offset <= {8{`OFS_RESET}};
    end else begin
      q <= d;
    end
  end

  assign activeCode = q.codeAct;
  assign activeSpan = q.spanAct;
  assign channelPowered = q.powered;

  // ---------------- checks ----------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  spanReset_a: assert property ($past(!rst_n) |-> q.spanIn == '0)
    else $error("span not zero after reset");
  overrangeSpan_a: assert property (
    fire && cmd[7:4] == `CMD_WR_SET && spanOk && spanField[3]
    |=> q.spanIn[$past(ch)] == $past(spanField))
    else $error("overrange span not stored");
  reservedSpan_a: assert property (
    fire && cmd[7:4] == `CMD_WR_SET && !spanOk |=> $stable(q.spanIn))
    else $error("reserved span changed setting");
  broadcastSet_a: assert property (
    fire && cmd == {`CMD_ALL, `ALL_WR_SET_UPD}
    |=> q.spanAct == q.spanIn && q.powered == 8'hff)
    else $error("broadcast update incomplete");
  updatePower_a: assert property (
    fire && cmd[7:4] == `CMD_UPD
    |=> q.powered[$past(ch)] &&
        q.codeAct[$past(ch)] == q.codeIn[$past(ch)] &&
        q.spanAct[$past(ch)] == q.spanIn[$past(ch)])
    else $error("update did not power channel");
  offsetHold_a: assert property (
    fire && cmd[7:4] == `CMD_WR_OFS
    |=> $stable(q.codeIn) ##1 $stable(q.codeAct))
    else $error("offset write moved code");
  offsetRead_a: assert property (
    fire && cmd[7:4] == `CMD_RD_OFS
    |=> q.resp[23:8] == {$past(q.offset[ch]), 2'b00})
    else $error("offset response wrong");
  // the link captures this word with no handshake, so it must stand
  // still between commands
  respQuiet_a: assert property (!fire |=> $stable(q.resp))
    else $error("response word moved between commands");
  poweredKeep_a: assert property (
    (q.powered & $past(q.powered)) == $past(q.powered))
    else $error("channel powered down");
  for (genvar g = 0; g < 8; g++) begin : gSpanLegal
    spanLegal_a: assert property (q.spanIn[g][2:0] <= `SPAN_MAX_LOW)
      else $error("reserved span stored");
  end
  configRead_a: assert property (
    fire && cmd == {`CMD_SYS, `SYS_RD_CFG}
    |=> q.resp[23] == $past(q.resetFlag) && q.resp[22:11] == '0 &&
        q.resp[10:8] == $past(q.cfgS2) && !q.resetFlag)
    else $error("config response wrong");
  adjRead_a: assert property (
    fire && cmd[7:4] == `CMD_RD_ADJ
    |=> q.resp[23:8] == $past(selCode) && q.resp[7:0] == 8'h00)
    else $error("adjusted code response wrong");
  plainCode_a: assert property (
    fire && cmd[7:4] == `CMD_WR_CODE && q.gain[ch] == '0 &&
    q.offset[ch] == '0 |=> q.codeIn[$past(ch)] == ($past(data) & CODE_MASK))
    else $error("unity adjust changed code");

  frameCover_c: cover property (fire && cmd == {`CMD_SYS, `SYS_RD_CFG});
  overCover_c: cover property (fire && cmd[7:4] == `CMD_WR_SET &&
                               spanField == 4'hc);
  allCover_c: cover property (fire && cmd == {`CMD_ALL, `ALL_WR_SET_UPD});
  gainCover_c: cover property (fire && cmd[7:4] == `CMD_WR_GAIN);
  codeAllCover_c: cover property (fire &&
                                  cmd == {`CMD_ALL, `ALL_WR_CODE_UPD});
endmodule // dac_span_offset_readback

// ### tb/host_link_model.sv
// host side of the serial link: frames commands, captures the response
`timescale 1ns/10ps
module host_link_model (
  output logic serialClock,
  output logic chipSelect_n,
  output logic serialDataIn,
  input wire logic serialDataOut
);
  initial begin
    serialClock = 1'b0;
    chipSelect_n = 1'b1;
    serialDataIn = 1'b0;
  end
  // link clock stands low between frames
  task automatic frame(input logic [7:0] cmd, input logic [15:0] data,
                       input int nBits, output logic [31:0] resp);
    logic [31:0] word;
    word = {cmd, data, 8'h00};
    resp = 32'h0;
    chipSelect_n = 1'b0;
    for (int i = 0; i < nBits; i++) begin
      serialDataIn = word[31-i];
      #16 serialClock = 1'b1;
      resp[31-i] = serialDataOut;
      #16 serialClock = 1'b0;
    end
    #16 chipSelect_n = 1'b1;
    // released line must not keep showing the last bit
    serialDataIn = ~serialDataIn;
    // odd gap keeps the link edges out of step with the core clock
    #103;
  endtask
endmodule // host_link_model

// ### tb/dac_span_offset_readback_bench.sv
// bench for the span, offset and readback logic
`timescale 1ns/10ps
module dac_span_offset_readback_bench;
  import dac_span_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, csN, serial_data_in, serial_data_out;
  logic tsd = 1'b1;
  logic ext = 1'b0;
  logic fce = 1'b1;
  code_type [7:0] actCode;
  span_type [7:0] actSpan;
  logic [7:0] powered;
  logic [31:0] r;
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;
  always #4 clock = ~clock;
  dac_span_offset_readback #(.CODE_BITS(16)) DUT (
    .clock(clock), .rst_n(rst_n), .serialClock(sclk),
    .chipSelect_n(csN), .serialDataIn(serial_data_in), .serialDataOut(serial_data_out),
    .thermalShutdownDisable(tsd), .externalReferenceSelect(ext),
    .frameCheckEnable(fce), .activeCode(actCode),
    .activeSpan(actSpan), .channelPowered(powered)
  );
  host_link_model host (
    .serialClock(sclk), .chipSelect_n(csN),
    .serialDataIn(serial_data_in), .serialDataOut(serial_data_out)
  );
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // a hung link or core stops the run here
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end
  function automatic logic [3:0] ch(input logic [2:0] n);
    return {n, 1'b0};
  endfunction
  task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
    host.frame(cmd, data, 24, r);
  endtask
  // read answer arrives in the following frame, sent as a no-op
  task automatic rd(input string what, input logic [7:0] cmd,
                    input logic [31:0] exp);
    host.frame(cmd, 16'h0000, 32, r);
    host.frame(8'hff, 16'h0000, 32, r);
    chk(what, exp, r);
  endtask
  task automatic adj(input logic [13:0] ofs, input logic [15:0] code,
                     input logic [15:0] exp);
    wr({4'h2, ch(3'd5)}, {ofs, 2'b00});
    wr({4'h4, ch(3'd5)}, code);
    rd("adjusted", {4'h8, ch(3'd5)}, {8'h00, exp, 8'h00});
    chk("active code", {16'h0, exp}, {16'h0, actCode[5]});
  endtask
  initial begin
    repeat (16) @(posedge clock);
    @(negedge clock) rst_n = 1'b1;
    repeat (4) @(negedge clock);
    chk("span reset", 32'h0, actSpan);
    chk("powered reset", 32'h0, {24'h0, powered});
    rd("config", 8'hf0, 32'h0080_0500);
    rd("config again", 8'hf0, 32'h0000_0500);
    @(negedge clock) {tsd, ext, fce} = 3'b010;
    rd("config pins", 8'hf0, 32'h0000_0200);
    wr({4'h1, ch(3'd2)}, 16'h0030);
    chk("span before update", 32'h0, {28'h0, actSpan[2]});
    wr({4'h6, ch(3'd2)}, 16'h0000);
    chk("span ch2", 32'hc, {28'h0, actSpan[2]});
    chk("powered", 32'h4, {24'h0, powered});
    wr({4'h1, ch(3'd2)}, 16'h0014);
    wr({4'h6, ch(3'd2)}, 16'h0000);
    chk("reserved span", 32'hc, {28'h0, actSpan[2]});
    for (int s = 0; s < 5; s++) begin
      wr(8'h7b, {10'h0, s[3:0], 2'b00});
      chk("span all", {8{s[3:0]}}, actSpan);
    end
    chk("powered all", 32'hff, {24'h0, powered});
    wr(8'h7a, 16'h0024);
    chk("span no update", 32'h4444_4444, actSpan);
    rd("settings", {4'h9, ch(3'd2)}, 32'h0000_2400);
    wr(8'h7c, 16'h0000);
    chk("overrange all", 32'h9999_9999, actSpan);
    wr({4'h0, ch(3'd1)}, 16'h1234);
    rd("plain code", {4'h8, ch(3'd1)}, 32'h0012_3400);
    wr({4'h3, ch(3'd3)}, 16'h8000);
    wr({4'h0, ch(3'd3)}, 16'h2000);
    rd("gain read", {4'hb, ch(3'd3)}, 32'h0080_0000);
    rd("gain code", {4'h8, ch(3'd3)}, 32'h0010_0000);
    wr({4'h5, ch(3'd3)}, 16'h2000);
    chk("update all", 32'h1000_0000, {actCode[3], actCode[0]});
    adj(14'h0005, 16'h1000, 16'h1005);
    wr({4'h2, ch(3'd5)}, 16'hffec);
    rd("offset pending", {4'h8, ch(3'd5)}, 32'h0010_0500);
    adj(14'h3ffb, 16'h1000, 16'h0ffb);
    adj(14'h3ffb, 16'h0002, 16'h0000);
    adj(14'h0005, 16'hffff, 16'hffff);
    rd("offset read", {4'ha, ch(3'd5)}, 32'h0000_1400);
    wr(8'h78, 16'h0100);
    chk("code all held", 32'h1000_0000, {actCode[3], actCode[0]});
    wr(8'h79, 16'h0200);
    chk("code all", 32'h0100_0200, {actCode[3], actCode[0]});
    chk("code all ch5", 32'h0000_0205, {16'h0, actCode[5]});
    results();
  end
endmodule // dac_span_offset_readback_bench
